/* File: src/srwp_defines.vh */
/*
 * constants for the configuration-status register write-protect block:
 * field positions, reset values, command codes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SRWP_DEFINES_VH
`define SRWP_DEFINES_VH

`define SRWP_BIT_PROT_HI 0
`define SRWP_BIT_QUAD_EN 1
`define SRWP_BIT_RSVD 2
`define SRWP_BIT_PROT_LO 7
`define SRWP_SL_LSB 3
`define SRWP_SL_MSB 5
`define SRWP_CFG_RESET 8'h00
`define SRWP_SL_RESET 3'h0

`define SRWP_CMD_WRSR1 8'h01
`define SRWP_CMD_WRSR2 8'h31
`define SRWP_CMD_WRSR3 8'h11
`define SRWP_CMD_WRSR4 8'h71

`define SRWP_CMD_QOR 8'h6b
`define SRWP_CMD_XIP 8'heb
`define SRWP_CMD_QALN 8'he7
`define SRWP_CMD_QPRG 8'h32
`define SRWP_CMD_BURST 8'h77
`define SRWP_CMD_QID 8'h94

`endif

/* File: src/srwp_status_protect.v */
/*
 * protection/configuration status register with status write protection.
 * holds security lock flags, quad mode enable and the protect-state machine.
 * assumes a command decoder on clk_i presents decoded command bytes with a
 * one-cycle strobe, the write enable latch level, last-byte-programmed
 * pulses for security registers, and non-volatile protect copies.
 * the write-protect pin arrives asynchronously and is synchronised here.
 */
`include "srwp_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module srwp_status_protect #(
  parameter NUM_SEC = 3
) (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire hw_reset_i,
  input wire sw_reset_i,
  // command path
  input wire cmd_valid_i,
  input wire [7:0] cmd_code_i,
  input wire [7:0] wr_data_i,
  input wire write_enable_latch_i,
  input wire [1:0] sec_reg_sel_i,
  input wire sec_last_byte_i,
  // non-volatile copies
  input wire nv_status_protect_hi_i,
  input wire nv_status_protect_lo_i,
  input wire permanent_lock_flag_i,
  // pins
  input wire wp_pin_i,
  input wire hold_reset_pin_i,
  // status
  output reg [7:0] protection_config_status_o,
  output reg status_protect_lo_o,
  output reg quad_mode_enable_o,
  output reg execute_in_place_mode_o,
  output reg wp_is_data_o,
  output reg hold_reset_is_data_o,
  output reg hold_active_o,
  output reg write_accept_o,
  output reg write_reject_o,
  output reg cmd_allowed_o,
  output reg [3:0] sec_locked_o
);

  ////////////////////////////////////////////////////////////////////////
  // one-hot protection states
  localparam [4:0] ST_SOFT = 5'h01;
  localparam [4:0] ST_HW = 5'h02;
  localparam [4:0] ST_LOCK0 = 5'h04;
  localparam [4:0] ST_LOCK1 = 5'h08;
  localparam [4:0] ST_OTP = 5'h10;

  function is_status_write;
    input [7:0] code;
    begin
      is_status_write = (code == `SRWP_CMD_WRSR1) || (code == `SRWP_CMD_WRSR2) ||
                        (code == `SRWP_CMD_WRSR3) || (code == `SRWP_CMD_WRSR4);
    end
  endfunction

  function is_quad_cmd;
    input [7:0] code;
    begin
      is_quad_cmd = (code == `SRWP_CMD_QOR) || (code == `SRWP_CMD_XIP) ||
                    (code == `SRWP_CMD_QALN) || (code == `SRWP_CMD_QPRG) ||
                    (code == `SRWP_CMD_BURST) || (code == `SRWP_CMD_QID);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg wp_meta_q;
  reg wp_sync_q;
  reg hold_meta_q;
  reg hold_sync_q;

  // write-protect pin, two flops before any use
  always @(posedge clk_i) begin
    wp_meta_q <= wp_pin_i;
    wp_sync_q <= wp_meta_q;
  end

  // hold/reset pin, two flops before any use
  always @(posedge clk_i) begin
    hold_meta_q <= hold_reset_pin_i;
    hold_sync_q <= hold_meta_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // protection state decode
  function [4:0] prot_state;
    input hi;
    input lo;
    input lock;
    begin
      case ({hi, lo})
        2'b00: prot_state = ST_SOFT;
        2'b01: prot_state = ST_HW;
        2'b10: prot_state = ST_LOCK0;
        default: prot_state = lock ? ST_OTP : ST_LOCK1;
      endcase
    end
  endfunction

  // volatile upper bit after a reset: only the permanent lock keeps it set
  function reload_hi;
    input nv_hi;
    input nv_lo;
    input lock;
    begin
      reload_hi = nv_hi & nv_lo & lock;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register state
  // one-hot state and its next value
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg prot_hi_q;
  reg prot_lo_q;
  reg quad_q;
  reg [NUM_SEC-1:0] sl_q;
  reg reload_q;
  reg any_reset;
  reg reload_now;
  reg wr_cmd;
  reg wr_ok;
  reg wr_take;
  reg nv_lock;

  // reset qualification
  always @* begin
    any_reset = rst_i | hw_reset_i | sw_reset_i;
    reload_now = reload_q | hw_reset_i | sw_reset_i;
    nv_lock = permanent_lock_flag_i;
  end

  // status write strobe
  always @* begin
    wr_cmd = cmd_valid_i & is_status_write(cmd_code_i);
  end

  // write permission
  always @* begin
    case (state_q)
      ST_SOFT: wr_ok = 1'b1;
      ST_HW: wr_ok = wp_sync_q | quad_q;
      ST_LOCK0: wr_ok = 1'b0;
      ST_LOCK1: wr_ok = 1'b0;
      ST_OTP: wr_ok = 1'b0;
      default: wr_ok = 1'b0;
    endcase
    wr_ok = wr_ok & write_enable_latch_i;
    // a write landing with any reset or the reload is dropped, never half taken
    wr_take = wr_cmd & wr_ok & ~any_reset & ~reload_q;
  end

  always @* begin
    state_d = prot_state(prot_hi_q, prot_lo_q, nv_lock);
  end

  ////////////////////////////////////////////////////////////////////////
  // protect bits and their one-hot state
  always @(posedge clk_i) begin
    if (rst_i) begin
      // power-on: volatile state cleared, non-volatile copy loaded next cycle
      prot_hi_q <= 1'b0;
      prot_lo_q <= 1'b0;
      reload_q <= 1'b1;
      state_q <= ST_SOFT;
    end else if (reload_now) begin
      reload_q <= 1'b0;
      prot_hi_q <= reload_hi(nv_status_protect_hi_i, nv_status_protect_lo_i,
                             nv_lock);
      prot_lo_q <= nv_status_protect_lo_i;
      // state follows the reloaded bits at once, no window with the old state
      state_q <= prot_state(reload_hi(nv_status_protect_hi_i, nv_status_protect_lo_i,
                            nv_lock), nv_status_protect_lo_i, nv_lock);
    end else begin
      state_q <= state_d;
      if (wr_take) begin
        prot_hi_q <= wr_data_i[`SRWP_BIT_PROT_HI];
        if (cmd_code_i == `SRWP_CMD_WRSR1) begin
          prot_lo_q <= wr_data_i[`SRWP_BIT_PROT_LO];
        end
      end
    end
  end

  // quad enable: cleared at power-on only, kept over pin and command resets
  always @(posedge clk_i) begin
    if (rst_i) begin
      quad_q <= 1'b0;
    end else if (wr_take) begin
      // lock and reserved positions are not taken from write data
      quad_q <= wr_data_i[`SRWP_BIT_QUAD_EN];
    end
  end

  // security locks: set by hardware only, a set never waits for a reload
  always @(posedge clk_i) begin
    if (rst_i) begin
      sl_q <= {NUM_SEC{1'b0}};
    end else if (sec_last_byte_i && sec_reg_sel_i != 2'h0) begin
      sl_q[sec_reg_sel_i - 2'h1] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register image
  always @(posedge clk_i) begin
    if (rst_i) begin
      protection_config_status_o <= `SRWP_CFG_RESET;
      status_protect_lo_o <= 1'b0;
      quad_mode_enable_o <= 1'b0;
    end else begin
      protection_config_status_o <= {2'h0, sl_q, 1'b0, quad_q, prot_hi_q};
      status_protect_lo_o <= prot_lo_q;
      quad_mode_enable_o <= quad_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin roles
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_is_data_o <= 1'b0;
      hold_reset_is_data_o <= 1'b0;
      hold_active_o <= 1'b0;
    end else begin
      wp_is_data_o <= quad_q;
      hold_reset_is_data_o <= quad_q;
      hold_active_o <= ~quad_q & ~hold_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write-status answers, one-cycle pulses
  always @(posedge clk_i) begin
    if (rst_i) begin
      write_accept_o <= 1'b0;
      write_reject_o <= 1'b0;
    end else begin
      write_accept_o <= wr_take;
      write_reject_o <= wr_cmd & ~wr_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command gate for quad-only commands
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_allowed_o <= 1'b0;
      execute_in_place_mode_o <= 1'b0;
    end else begin
      cmd_allowed_o <= cmd_valid_i & (~is_quad_cmd(cmd_code_i) | quad_q);
      execute_in_place_mode_o <= quad_q & cmd_valid_i & (cmd_code_i == `SRWP_CMD_XIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // security lock view, register zero always locked
  always @(posedge clk_i) begin
    if (rst_i) begin
      sec_locked_o <= 4'h1;
    end else begin
      sec_locked_o <= {sl_q, 1'b1};
    end
  end

endmodule // srwp_status_protect

`default_nettype wire

/* File: verif/srwp_host_model.sv */
/* host command model: one-cycle command strobes; assumes clk_i only */
`timescale 1ns/1ps
`default_nettype none
module srwp_host_model (
  input wire logic clk_i,
  output logic cmd_valid_o, output logic [7:0] cmd_code_o, output logic [7:0] wr_data_o);
  initial {cmd_valid_o, cmd_code_o, wr_data_o} = 17'h0;
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i) {cmd_valid_o, cmd_code_o, wr_data_o} <= {1'b1, c, d};
    // released lines show the inverse, never a stale copy
    @(posedge clk_i) {cmd_valid_o, cmd_code_o, wr_data_o} <= {1'b0, ~c, ~d};
  endtask
endmodule // srwp_host_model
`default_nettype wire

/* File: verif/srwp_status_protect_chk.sv */
/* port checker for the status-protect block; assumes one clock, sync reset */
`timescale 1ns/1ps
`default_nettype none
module srwp_status_protect_chk (
  input wire logic clk_i, rst_i, hw_reset_i, sw_reset_i, cmd_valid_i, write_enable_latch_i,
  input wire logic [7:0] cmd_code_i, protection_config_status_o,
  input wire logic nv_status_protect_hi_i, nv_status_protect_lo_i, permanent_lock_flag_i,
  input wire logic status_protect_lo_o, quad_mode_enable_o, wp_is_data_o, cmd_allowed_o,
  input wire logic write_accept_o, write_reject_o,
  input wire logic [3:0] sec_locked_o);
  wire logic [7:0] s = protection_config_status_o;
  wire logic ws = cmd_valid_i && !hw_reset_i && !sw_reset_i &&
    (cmd_code_i inside {8'h01, 8'h31, 8'h11, 8'h71});
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  latch_refuse_a: assert property (ws && !write_enable_latch_i |=> write_reject_o)
    else $error("write without latch not refused");
  open_accept_a: assert property (ws && write_enable_latch_i && !s[0] && !status_protect_lo_o
    |=> write_accept_o && !write_reject_o)
    else $error("open state write not accepted");
  lockdown_refuse_a: assert property (ws && s[0] |=> write_reject_o)
    else $error("lockdown write not refused");
  quad_pins_a: assert property (wp_is_data_o == quad_mode_enable_o && s[1] == wp_is_data_o)
    else $error("pin role differs from quad bit");
  lock_map_a: assert property (s[5:3] == sec_locked_o[3:1] && sec_locked_o[0])
    else $error("lock field mismatch");
  fixed_zero_a: assert property (s[2] == 1'b0 && s[7:6] == 2'b00)
    else $error("read-only bits changed");
  lock_sticky_a: assert property (!$past(rst_i)
    |-> (sec_locked_o & $past(sec_locked_o)) == $past(sec_locked_o))
    else $error("lock bit cleared");
  quad_gate_a: assert property (cmd_valid_i && cmd_code_i == 8'h6b && !quad_mode_enable_o
    |=> !cmd_allowed_o)
    else $error("quad command allowed without quad");
  otp_reload_a: assert property (sw_reset_i && nv_status_protect_hi_i && nv_status_protect_lo_i
    && permanent_lock_flag_i |-> ##[1:2] s[0] && status_protect_lo_o)
    else $error("permanent lock lost on reset");
  cover property (ws && write_enable_latch_i ##1 write_accept_o);
  cover property (ws && s[0] ##1 write_reject_o);
  cover property (sw_reset_i && permanent_lock_flag_i);
endmodule // srwp_status_protect_chk
bind srwp_status_protect srwp_status_protect_chk i_chk (.*);
`default_nettype wire

/* File: verif/testbench.sv */
/* top bench: host model on the command port; checker bound to the design */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  logic clk_i = 0, rst_i = 1, hw = 0, sw = 0, write_enable_latch = 0, slb = 0, nvh = 0, nvl = 0, plk = 0;
  logic wp = 0, hold = 1, cv, plo, qe, execute_in_place_mode, wpd, hrd, hact, acc, rej, alw, e;
  logic [1:0] sel = 0;
  logic [3:0] sl;
  logic [7:0] st, cc, wd, d;
  int miscompares = 0, checks_done = 0;
  logic exp_q[$];
  logic [7:0] qcmd[6] = '{8'h6b, 8'heb, 8'he7, 8'h32, 8'h77, 8'h94};
  srwp_host_model i_host (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_code_o(cc), .wr_data_o(wd));
  srwp_status_protect i_dut (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_i(hw), .sw_reset_i(sw),
    .cmd_valid_i(cv), .cmd_code_i(cc), .wr_data_i(wd), .write_enable_latch_i(write_enable_latch),
    .sec_reg_sel_i(sel), .sec_last_byte_i(slb), .nv_status_protect_hi_i(nvh),
    .nv_status_protect_lo_i(nvl), .permanent_lock_flag_i(plk), .wp_pin_i(wp),
    .hold_reset_pin_i(hold), .protection_config_status_o(st), .status_protect_lo_o(plo),
    .quad_mode_enable_o(qe), .execute_in_place_mode_o(execute_in_place_mode), .wp_is_data_o(wpd),
    .hold_reset_is_data_o(hrd), .hold_active_o(hact), .write_accept_o(acc),
    .write_reject_o(rej), .cmd_allowed_o(alw), .sec_locked_o(sl));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (acc || rej) begin
    e = exp_q.pop_front();
    `CHK(acc, e)
  end
  task automatic wr(input logic [7:0] c, input logic [7:0] v, input logic ok);
    exp_q.push_back(ok);
    i_host.send(c, v);
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i) {rst_i, hw, sw} <= m;
    @(posedge clk_i) {rst_i, hw, sw} <= 3'b000;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic complete_run;
    if (exp_q.size() != 0) miscompares++;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  initial begin
    d = 8'($urandom(32'hf3564a1e));
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK({st, sl}, 12'h001)
    wr(8'h31, 8'h02, 0);
    @(posedge clk_i) {write_enable_latch, hold} <= 2'b10;
    wr(8'h71, {1'b0, d[6:2], 2'b10}, 1);
    `CHK({st, wpd, hrd, hact}, 11'h016)
    foreach (qcmd[i]) begin
      i_host.send(qcmd[i], 8'h00);
      #1;
      `CHK({alw, execute_in_place_mode}, {1'b1, qcmd[i] == 8'heb})
    end
    wr(8'h31, 8'h00, 1);
    i_host.send(8'h6b, 8'h00);
    #1;
    `CHK({alw, wpd, hact}, 3'b001)
    $display("test quad mode done");
    wr(8'h01, 8'h80, 1);
    wr(8'h31, 8'h02, 0);
    @(posedge clk_i) {wp, nvh, nvl} <= 3'b111;
    repeat (2) @(posedge clk_i);
    wr(8'h31, 8'h02, 1);
    wr(8'h01, 8'h81, 1);
    wr(8'h31, 8'h02, 0);
    pulse(3'b010);
    `CHK({st[1:0], plo}, 3'b001)
    wr(8'h01, 8'h01, 1);
    wr(8'h31, 8'h02, 0);
    @(posedge clk_i) nvl <= 0;
    pulse(3'b100);
    `CHK({st[0], plo}, 2'b00)
    wr(8'h01, 8'h81, 1);
    @(posedge clk_i) {nvl, plk} <= 2'b11;
    pulse(3'b001);
    `CHK({st[0], plo}, 2'b11)
    wr(8'h31, 8'h02, 0);
    $display("test protect states done");
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_i) {sel, slb} <= {2'(i), 1'b1};
      @(posedge clk_i) slb <= 0;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK({sl[i], st[i+2]}, 2'b11)
    end
    $display("test security locks done");
    complete_run;
  end
endmodule // testbench
`default_nettype wire
